/* core/adcs_pkg.sv */
package adcs_pkg;
    // address layout
    localparam int ADDR_W = 32;
    localparam int OFF_W = 24;
    localparam int PHYS_W = 22;
    localparam int AD_W = 16;
    localparam int AREA_LSB = 24;
    localparam int AREA_MSB = 26;
    localparam int WIDTH_BIT = 27;
    localparam int PERIPH_W_BIT = 8;
    localparam int MUXIO_W_BIT = 14;
    localparam int DRAM_COL_W = 12;

    // area numbers with special meaning
    localparam logic [2:0] AREA_ROM = 3'h0;
    localparam logic [2:0] AREA_DRAM = 3'h1;
    localparam logic [2:0] AREA_PERIPH = 3'h5;
    localparam logic [2:0] AREA_MUXIO = 3'h6;
    localparam logic [2:0] AREA_RAM = 3'h7;

    // boot mode pin codes
    localparam logic [2:0] BOOT_EXT8 = 3'h0;
    localparam logic [2:0] BOOT_EXT16 = 3'h1;
    localparam logic [2:0] BOOT_ROM = 3'h2;

    // pin values
    localparam logic [7:0] SEL_IDLE = 8'hFF;
    localparam logic [15:0] LANE_ALL = 16'hFFFF;
    localparam logic [15:0] LANE_HI = 16'hFF00;
    localparam logic [15:0] LANE_LO = 16'h00FF;
    localparam logic [15:0] LANE_NONE = 16'h0000;

    typedef enum logic [2:0] {
        SP_EXT = 3'h0,
        SP_DRAM = 3'h1,
        SP_MUXIO = 3'h2,
        SP_ROM = 3'h3,
        SP_PERIPH = 3'h4,
        SP_RAM = 3'h5
    } adcs_space_t;

    typedef enum logic [1:0] {
        BW_8 = 2'h0,
        BW_16 = 2'h1,
        BW_32 = 2'h2
    } adcs_width_t;

    typedef enum logic [1:0] {
        SZ_BYTE = 2'h0,
        SZ_WORD = 2'h1,
        SZ_LONG = 2'h2
    } adcs_size_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ADDR = 3'b010,
        ST_BEAT = 3'b100
    } adcs_state_t;

    // on-chip targets never see a chip select
    function automatic logic adcs_internal(input adcs_space_t sp);
        return (sp == SP_ROM) || (sp == SP_PERIPH) || (sp == SP_RAM);
    endfunction

    // number of bus cycles for one cpu access
    function automatic logic [2:0] adcs_beats(input adcs_size_t sz,
                                              input adcs_width_t w);
        logic [2:0] n;
        n = 3'h1;
        if (w == BW_8 && sz == SZ_WORD) begin
            n = 3'h2;
        end else if (w == BW_8 && sz == SZ_LONG) begin
            n = 3'h4;
        end else if (w == BW_16 && sz == SZ_LONG) begin
            n = 3'h2;
        end
        return n;
    endfunction
endpackage

/* core/adcs_area_map.sv */
`timescale 1ns/100ps
module adcs_area_map
    import adcs_pkg::*;
(
    // cpu address and straps
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [2:0] boot_mode_pins,
    input wire logic dram_space_enable,
    input wire logic muxed_io_enable,
    // decoded result
    output logic [2:0] area,
    output adcs_space_t space,
    output adcs_width_t width
);
    logic hi;

    // area, space type and width from the address, boot pins and space enables
    always_comb begin
        area = addr[AREA_MSB:AREA_LSB];
        hi = addr[WIDTH_BIT];
        width = hi ? BW_16 : BW_8;
        space = SP_EXT;
        if (area == AREA_ROM) begin
            if (boot_mode_pins == BOOT_ROM) begin
                space = SP_ROM;
                width = BW_32;
            end else if (boot_mode_pins == BOOT_EXT16) begin
                width = BW_16;
            end else begin
                width = BW_8; // reserved codes act as 8-bit external
            end
        end else if (area == AREA_DRAM) begin
            if (dram_space_enable) begin
                space = SP_DRAM;
            end
        end else if (area == AREA_PERIPH) begin
            // peripheral half split on bit 8
            if (!hi) begin
                space = SP_PERIPH;
                width = addr[PERIPH_W_BIT] ? BW_16 : BW_8;
            end
        end else if (area == AREA_MUXIO) begin
            // lower half split on bit 14
            if (!hi) begin
                width = addr[MUXIO_W_BIT] ? BW_16 : BW_8;
                if (muxed_io_enable) begin
                    space = SP_MUXIO;
                end
            end
        end else if (area == AREA_RAM) begin
            if (hi) begin
                space = SP_RAM;
                width = BW_32;
            end else begin
                width = BW_8;
            end
        end
    end
endmodule // adcs_area_map

/* core/adcs_decoder.sv */
// How it works
// - address bits 31..28 are ignored and never reach any pin.
// - bit 27 picks 8-bit (0) or 16-bit (1) width unless area overrides.
// - bits 26..24 split space into eight 16 MB areas, 000 to 111.
// - only the accessed area's low-active select is driven, index = bits 26..24.
// - selects only on external accesses; on-chip rom, peripheral, ram stay high.
// - boot pins 000 ext 8-bit, 001 ext 16-bit, 010 on-chip 32-bit rom.
// - area 5 low half is peripherals, width by bit 8; high half 16-bit.
// - area 6 low half width by bit 14; high half always 16-bit.
// - area 7 high half is 32-bit on-chip ram, low half 8-bit external.
// - area 1 is dram or plain memory by dram space enable.
// - area 6 low half is muxed io or plain memory by muxed io enable.
// - 8-bit uses pins 7..0; words all 16; bytes split high and low lanes.
// - wide accesses split: word/8 two, long/16 two, long/8 four cycles.
// - bits 23 and 22 are not output except dram address multiplexing.
// - in areas 0 to 4 both bit-27 halves reach the same locations; only lanes differ.
// - dram multiplexing puts the 24-bit offset on twelve low pins.
`timescale 1ns/100ps
module adcs_decoder
    import adcs_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // cpu request
    input wire logic req_valid,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire adcs_size_t req_size,
    input wire logic req_write,
    input wire logic [31:0] req_wdata,
    output logic req_ready,
    output logic resp_valid,
    output logic [31:0] resp_rdata,
    // configuration
    input wire logic [2:0] boot_mode_pins,
    input wire logic dram_space_enable,
    input wire logic muxed_io_enable,
    input wire logic dram_addr_mux_enable,
    // external bus
    output logic [7:0] area_select_n,
    output logic [PHYS_W-1:0] addr_pins,
    input wire logic [AD_W-1:0] addr_data_pins_in,
    output logic [AD_W-1:0] addr_data_pins_out,
    output logic [AD_W-1:0] addr_data_pins_oe,
    output logic ext_rd_n,
    output logic ext_wr_n,
    output logic dram_cycle,
    output logic dram_row_phase,
    output logic muxio_cycle,
    // on-chip targets
    output logic int_strobe,
    output adcs_space_t int_space,
    output logic [OFF_W-1:0] int_addr,
    output adcs_size_t int_size,
    output logic int_write,
    output logic [31:0] int_wdata,
    input wire logic [31:0] int_rdata
);
    logic [2:0] dec_area;
    adcs_space_t dec_space;
    adcs_width_t dec_width;

    adcs_area_map adcs_area_map_i (
        .addr(req_addr),
        .boot_mode_pins(boot_mode_pins),
        .dram_space_enable(dram_space_enable),
        .muxed_io_enable(muxed_io_enable),
        .area(dec_area),
        .space(dec_space),
        .width(dec_width)
    );

    adcs_state_t state_reg, state_next;
    logic [2:0] area_reg, area_next;
    adcs_space_t space_reg, space_next;
    adcs_width_t width_reg, width_next;
    adcs_size_t size_reg, size_next;
    logic write_reg, write_next;
    logic mux_reg, mux_next;
    logic [OFF_W-1:0] off_reg, off_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [2:0] beat_reg, beat_next;
    logic [2:0] nbeats_reg, nbeats_next;
    logic resp_reg, resp_next;
    logic [7:0] sel_n_reg, sel_n_next;
    logic [PHYS_W-1:0] apin_reg, apin_next;
    logic [AD_W-1:0] ad_reg, ad_next;
    logic [AD_W-1:0] oe_reg, oe_next;
    logic rd_n_reg, rd_n_next;
    logic wr_n_reg, wr_n_next;
    logic dram_reg, dram_next;
    logic row_reg, row_next;
    logic mio_reg, mio_next;
    logic istb_reg, istb_next;
    logic [OFF_W-1:0] cur;
    logic [2:0] idx;
    logic [31:0] chunk;
    logic ext;

    // handshake is combinational: a new access only from idle
    assign req_ready = (state_reg == ST_IDLE);

    // sequencing: accept, optional address phase, one cycle per beat
    always_comb begin
        state_next = state_reg;
        area_next = area_reg;
        space_next = space_reg;
        width_next = width_reg;
        size_next = size_reg;
        write_next = write_reg;
        mux_next = mux_reg;
        off_next = off_reg;
        wdata_next = wdata_reg;
        rdata_next = rdata_reg;
        beat_next = beat_reg;
        nbeats_next = nbeats_reg;
        resp_next = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (req_valid) begin
                    area_next = dec_area;
                    space_next = dec_space;
                    width_next = dec_width;
                    size_next = req_size;
                    write_next = req_write;
                    mux_next = dram_addr_mux_enable;
                    off_next = req_addr[OFF_W-1:0];
                    wdata_next = req_wdata;
                    rdata_next = 32'h0000_0000;
                    beat_next = 3'h0;
                    nbeats_next = adcs_beats(req_size, dec_width);
                    if ((dec_space == SP_DRAM && dram_addr_mux_enable)
                        || dec_space == SP_MUXIO) begin
                        state_next = ST_ADDR;
                    end else begin
                        state_next = ST_BEAT;
                    end
                end
            end
            ST_ADDR: begin
                state_next = ST_BEAT;
            end
            ST_BEAT: begin
                // read data gathered most significant part first
                if (!write_reg) begin
                    if (adcs_internal(space_reg)) begin
                        rdata_next = int_rdata;
                    end else if (width_reg == BW_8) begin
                        rdata_next = {rdata_reg[23:0],
                                      addr_data_pins_in[7:0]};
                    end else if (size_reg == SZ_BYTE) begin
                        rdata_next = {24'h00_0000, off_reg[0] ?
                                      addr_data_pins_in[7:0] :
                                      addr_data_pins_in[15:8]};
                    end else begin
                        rdata_next = {rdata_reg[15:0], addr_data_pins_in};
                    end
                end
                if (beat_reg + 3'h1 == nbeats_reg) begin
                    state_next = ST_IDLE;
                    resp_next = 1'b1;
                end else begin
                    beat_next = beat_reg + 3'h1;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // pin values for the cycle that the next state describes
    always_comb begin
        ext = (state_next != ST_IDLE) && !adcs_internal(space_next);
        if (width_next == BW_8) begin
            cur = off_next + {21'h00_0000, beat_next};
        end else if (width_next == BW_16) begin
            cur = off_next + {20'h00_0000, beat_next, 1'b0};
        end else begin
            cur = off_next;
        end
        idx = nbeats_next - 3'h1 - beat_next;
        if (width_next == BW_8) begin
            chunk = wdata_next >> {idx[1:0], 3'b000};
        end else begin
            chunk = wdata_next >> {idx[0], 4'h0};
        end
        sel_n_next = SEL_IDLE;
        if (ext && space_next != SP_DRAM) begin
            sel_n_next[area_next] = 1'b0;
        end
        apin_next = cur[PHYS_W-1:0];
        if (state_next == ST_IDLE) begin
            apin_next = '0;
        end else if (space_next == SP_DRAM && mux_next) begin
            // row then column on low pins
            if (state_next == ST_ADDR) begin
                apin_next = {10'h000, cur[OFF_W-1:DRAM_COL_W]};
            end else begin
                apin_next = {10'h000, cur[DRAM_COL_W-1:0]};
            end
        end
        ad_next = 16'h0000;
        oe_next = LANE_NONE;
        if (state_next == ST_ADDR && space_next == SP_MUXIO) begin
            ad_next = cur[AD_W-1:0];
            oe_next = LANE_ALL;
        end else if (state_next == ST_BEAT && ext && write_next) begin
            if (width_next == BW_8) begin
                ad_next = {8'h00, chunk[7:0]};
                oe_next = LANE_LO;
            end else if (size_next == SZ_BYTE && !cur[0]) begin
                ad_next = {chunk[7:0], 8'h00};
                oe_next = LANE_HI;
            end else if (size_next == SZ_BYTE) begin
                ad_next = {8'h00, chunk[7:0]};
                oe_next = LANE_LO;
            end else begin
                ad_next = chunk[15:0];
                oe_next = LANE_ALL;
            end
        end
        rd_n_next = !(state_next == ST_BEAT && ext && !write_next);
        wr_n_next = !(state_next == ST_BEAT && ext && write_next);
        dram_next = ext && space_next == SP_DRAM;
        row_next = dram_next && state_next == ST_ADDR;
        mio_next = ext && space_next == SP_MUXIO;
        // longwords to 8-bit peripherals take four beats, one strobe each
        istb_next = (state_next == ST_BEAT) && !ext;
    end

    // all state registered on every edge
    always_ff @(posedge clock) begin
        if (!rstn) begin
            state_reg <= ST_IDLE;
            area_reg <= 3'h0;
            space_reg <= SP_EXT;
            width_reg <= BW_8;
            size_reg <= SZ_BYTE;
            write_reg <= 1'b0;
            mux_reg <= 1'b0;
            off_reg <= '0;
            wdata_reg <= 32'h0000_0000;
            rdata_reg <= 32'h0000_0000;
            beat_reg <= 3'h0;
            nbeats_reg <= 3'h1;
            resp_reg <= 1'b0;
            sel_n_reg <= SEL_IDLE;
            apin_reg <= '0;
            ad_reg <= 16'h0000;
            oe_reg <= LANE_NONE;
            rd_n_reg <= 1'b1;
            wr_n_reg <= 1'b1;
            dram_reg <= 1'b0;
            row_reg <= 1'b0;
            mio_reg <= 1'b0;
            istb_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            area_reg <= area_next;
            space_reg <= space_next;
            width_reg <= width_next;
            size_reg <= size_next;
            write_reg <= write_next;
            mux_reg <= mux_next;
            off_reg <= off_next;
            wdata_reg <= wdata_next;
            rdata_reg <= rdata_next;
            beat_reg <= beat_next;
            nbeats_reg <= nbeats_next;
            resp_reg <= resp_next;
            sel_n_reg <= sel_n_next;
            apin_reg <= apin_next;
            ad_reg <= ad_next;
            oe_reg <= oe_next;
            rd_n_reg <= rd_n_next;
            wr_n_reg <= wr_n_next;
            dram_reg <= dram_next;
            row_reg <= row_next;
            mio_reg <= mio_next;
            istb_reg <= istb_next;
        end
    end

    // outputs straight from flip-flops
    assign resp_valid = resp_reg;
    assign resp_rdata = rdata_reg;
    assign area_select_n = sel_n_reg;
    assign addr_pins = apin_reg;
    assign addr_data_pins_out = ad_reg;
    assign addr_data_pins_oe = oe_reg;
    assign ext_rd_n = rd_n_reg;
    assign ext_wr_n = wr_n_reg;
    assign dram_cycle = dram_reg;
    assign dram_row_phase = row_reg;
    assign muxio_cycle = mio_reg;
    assign int_strobe = istb_reg;
    assign int_space = space_reg;
    assign int_addr = off_reg;
    assign int_size = size_reg;
    assign int_write = write_reg;
    assign int_wdata = wdata_reg;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    logic take;
    assign take = req_valid && req_ready;

    sequence s_beat;
        (state_reg == ST_BEAT) && !resp_valid;
    endsequence
    sequence s_two_beats;
        s_beat [*2] ##1 resp_valid;
    endsequence
    sequence s_four_beats;
        s_beat [*4] ##1 resp_valid;
    endsequence

    AST_IDLE_DESELECT: assert property (
        state_reg == ST_IDLE |-> area_select_n == SEL_IDLE)
        else $error("select low while idle");
    AST_ONE_SELECT: assert property (
        $onehot0(~area_select_n))
        else $error("more than one select low");
    AST_SELECT_AREA: assert property (
        take && !adcs_internal(dec_space) && dec_space != SP_DRAM
        |=> area_select_n == ~(8'h01 << $past(dec_area)))
        else $error("wrong area select");
    AST_NO_SELECT_ONCHIP: assert property (
        int_strobe |-> area_select_n == SEL_IDLE && ext_rd_n && ext_wr_n)
        else $error("select on on-chip access");
    AST_ROM_BOOT: assert property (
        take && req_addr[AREA_MSB:AREA_LSB] == AREA_ROM
        && boot_mode_pins == BOOT_ROM
        |=> int_strobe && int_space == SP_ROM ##1 resp_valid)
        else $error("rom boot not on-chip");
    AST_LONG_ON_8: assert property (
        take && req_size == SZ_LONG && dec_width == BW_8
        && dec_space == SP_EXT |=> s_four_beats)
        else $error("longword on 8-bit not four cycles");
    AST_WORD_ON_8: assert property (
        take && req_size == SZ_WORD && dec_width == BW_8
        && dec_space == SP_EXT |=> s_two_beats)
        else $error("word on 8-bit not two cycles");
    AST_SHADOW_ADDR: assert property (
        take && dec_space == SP_EXT && req_size == SZ_BYTE
        |=> addr_pins == $past(req_addr[PHYS_W-1:0]))
        else $error("address pins not shadow offset");
    AST_BYTE_HIGH_LANE: assert property (
        take && req_write && req_size == SZ_BYTE && dec_width == BW_16
        && dec_space == SP_EXT && !req_addr[0]
        |=> addr_data_pins_oe == LANE_HI
        && addr_data_pins_out[15:8] == $past(req_wdata[7:0]))
        else $error("even byte not on upper lane");
    AST_DRAM_ROW: assert property (
        take && dec_space == SP_DRAM && dram_addr_mux_enable
        |=> dram_row_phase && area_select_n == SEL_IDLE
        && addr_pins == {10'h000, $past(req_addr[23:12])}
        ##1 !dram_row_phase && dram_cycle)
        else $error("dram row phase wrong");
    AST_MUXIO_ADDR: assert property (
        take && dec_space == SP_MUXIO
        |=> muxio_cycle && addr_data_pins_oe == LANE_ALL
        && addr_data_pins_out == $past(req_addr[AD_W-1:0]))
        else $error("muxed io address phase wrong");
endmodule // adcs_decoder

/* tb/adcs_ext_mem.sv */
`timescale 1ns/100ps
module adcs_ext_mem
    import adcs_pkg::*;
(
    // clock and width hint
    input wire logic clock,
    input wire logic bus16,
    // external bus
    input wire logic [7:0] area_select_n,
    input wire logic [PHYS_W-1:0] addr_pins,
    input wire logic [AD_W-1:0] addr_data_pins_out,
    input wire logic [AD_W-1:0] addr_data_pins_oe,
    input wire logic ext_rd_n,
    input wire logic ext_wr_n,
    output logic [AD_W-1:0] addr_data_pins_in,
    // on-chip targets
    input wire logic [OFF_W-1:0] int_addr,
    output logic [31:0] int_rdata
);
    logic [7:0] mem [0:255];
    logic [7:0] a;
    logic [15:0] last = 16'h0000;

    // only low offset bits reach the part
    assign a = addr_pins[7:0];
    // on-chip targets answer a pattern of their offset
    assign int_rdata = {8'hC3, int_addr};

    // store by active lanes; even byte sits on the high lane
    always @(posedge clock) begin
        if (!ext_wr_n && area_select_n != SEL_IDLE) begin
            if (addr_data_pins_oe[15]) begin
                mem[{a[7:1], 1'b0}] <= addr_data_pins_out[15:8];
            end
            if (addr_data_pins_oe[0]) begin
                mem[addr_data_pins_oe[15] ? (a | 8'h01) : a] <=
                    addr_data_pins_out[7:0];
            end
        end
        if (!ext_rd_n) begin
            last <= addr_data_pins_in;
        end
    end

    // read lanes; released lines show the inverse of the last value
    always_comb begin
        addr_data_pins_in = ~last;
        if (!ext_rd_n && area_select_n != SEL_IDLE) begin
            addr_data_pins_in = bus16 ? {mem[{a[7:1], 1'b0}], mem[a | 8'h01]}
                                      : {~last[15:8], mem[a]};
        end
    end
endmodule // adcs_ext_mem

/* tb/adcs_decoder_tb_top.sv */
`timescale 1ns/100ps
module adcs_decoder_tb_top
    import adcs_pkg::*;
;
    logic clock, rstn, req_valid, req_write, req_ready, resp_valid, bus16;
    logic [31:0] req_addr, req_wdata, resp_rdata, int_rdata;
    adcs_size_t req_size;
    logic [2:0] boot_mode_pins;
    logic dram_space_enable, muxed_io_enable, dram_addr_mux_enable;
    logic [7:0] area_select_n;
    logic [PHYS_W-1:0] addr_pins;
    logic [AD_W-1:0] ad_in, ad_out, ad_oe, oe_seen;
    logic ext_rd_n, ext_wr_n;
    logic [OFF_W-1:0] int_addr;
    int mismatches = 0;
    int checks_done = 0;
    int cyc_cnt = 0;

    adcs_decoder adcs_decoder_i (.clock(clock), .rstn(rstn),
        .req_valid(req_valid), .req_addr(req_addr), .req_size(req_size),
        .req_write(req_write), .req_wdata(req_wdata), .req_ready(req_ready),
        .resp_valid(resp_valid), .resp_rdata(resp_rdata),
        .boot_mode_pins(boot_mode_pins),
        .dram_space_enable(dram_space_enable),
        .muxed_io_enable(muxed_io_enable),
        .dram_addr_mux_enable(dram_addr_mux_enable),
        .area_select_n(area_select_n), .addr_pins(addr_pins),
        .addr_data_pins_in(ad_in), .addr_data_pins_out(ad_out),
        .addr_data_pins_oe(ad_oe), .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n),
        .dram_cycle(), .dram_row_phase(), .muxio_cycle(), .int_strobe(),
        .int_space(), .int_addr(int_addr), .int_size(), .int_write(),
        .int_wdata(), .int_rdata(int_rdata));

    adcs_ext_mem adcs_ext_mem_i (.clock(clock), .bus16(bus16),
        .area_select_n(area_select_n), .addr_pins(addr_pins),
        .addr_data_pins_out(ad_out), .addr_data_pins_oe(ad_oe),
        .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n), .addr_data_pins_in(ad_in),
        .int_addr(int_addr), .int_rdata(int_rdata));

    // free-running clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic give_verdict();
        $display("mismatches %0d checks_done %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cfg(input logic [2:0] bm, input logic de, input logic ie,
                       input logic me);
        @(posedge clock);
        boot_mode_pins <= bm;
        dram_space_enable <= de;
        muxed_io_enable <= ie;
        dram_addr_mux_enable <= me;
    endtask

    // one cpu access; counts edges to the answer, merges selects seen
    task automatic acc(input logic [31:0] a, input adcs_size_t sz,
                       input logic wr, input logic [31:0] d, input logic w16,
                       input int cyc, input logic [7:0] sel);
        int n;
        logic [7:0] s;
        @(posedge clock);
        req_valid <= 1'b1;
        req_addr <= a;
        req_size <= sz;
        req_write <= wr;
        req_wdata <= d;
        bus16 <= w16;
        @(posedge clock);
        chk("ready", 32'h1, {31'h0, req_ready});
        req_valid <= 1'b0;
        n = 0;
        s = SEL_IDLE;
        oe_seen = LANE_NONE;
        do begin
            @(posedge clock);
            n++;
            s = s & area_select_n;
            oe_seen = oe_seen | ad_oe;
        end while (resp_valid !== 1'b1 && n < 40);
        chk("cycles", 32'(cyc), 32'(n));
        chk("select", {24'h0, sel}, {24'h0, s});
    endtask

    // hang guard, well above the expected run length
    always @(posedge clock) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            mismatches++;
            give_verdict();
        end
    end

    initial begin
        rstn = 1'b0;
        req_valid = 1'b0;
        req_addr = 32'h0;
        req_size = SZ_BYTE;
        req_write = 1'b0;
        req_wdata = 32'h0;
        bus16 = 1'b0;
        boot_mode_pins = BOOT_EXT8;
        dram_space_enable = 1'b0;
        muxed_io_enable = 1'b0;
        dram_addr_mux_enable = 1'b0;
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        chk("idle_sel", {24'h0, SEL_IDLE}, {24'h0, area_select_n});
        // one select per area, none for peripherals
        for (int k = 0; k < 8; k++) begin
            acc({5'h0, 3'(k), 24'h10}, SZ_BYTE, 1'b0, 32'h0, 1'b0, 2,
                (k == 5) ? SEL_IDLE : ~(8'h01 << k));
        end
        // byte write on 8-bit area drives low lane only
        acc(32'h2000011, SZ_BYTE, 1'b1, 32'h5A, 1'b0, 2, 8'hFB);
        chk("lanes8", {16'h0, LANE_LO}, {16'h0, oe_seen});
        // long on 8-bit area takes four beats
        acc(32'h2000020, SZ_LONG, 1'b1, 32'h11223344, 1'b0, 5, 8'hFB);
        acc(32'h2000020, SZ_LONG, 1'b0, 32'h0, 1'b0, 5, 8'hFB);
        chk("long8", 32'h11223344, resp_rdata);
        // write through 16-bit half, read through 8-bit half
        acc(32'hA000040, SZ_LONG, 1'b1, 32'hA1B2C3D4, 1'b1, 3, 8'hFB);
        chk("lanes16", {16'h0, LANE_ALL}, {16'h0, oe_seen});
        acc(32'h2000040, SZ_LONG, 1'b0, 32'h0, 1'b0, 5, 8'hFB);
        chk("alias", 32'hA1B2C3D4, resp_rdata);
        // bytes on 16-bit bus: odd low lane, even high lane
        acc(32'hA000041, SZ_BYTE, 1'b0, 32'h0, 1'b1, 2, 8'hFB);
        chk("odd", 32'hB2, resp_rdata & 32'hFF);
        acc(32'hA000042, SZ_BYTE, 1'b0, 32'h0, 1'b1, 2, 8'hFB);
        chk("even", 32'hC3, resp_rdata & 32'hFF);
        // even byte write on a 16-bit bus uses the upper lane only
        acc(32'hA000044, SZ_BYTE, 1'b1, 32'h5A, 1'b1, 2, 8'hFB);
        chk("lanes_hi", {16'h0, LANE_HI}, {16'h0, oe_seen});
        acc(32'hA000044, SZ_BYTE, 1'b0, 32'h0, 1'b1, 2, 8'hFB);
        chk("even_wr", 32'h5A, resp_rdata);
        // top nibble and shadow bits reach the same place
        acc(32'hF2C00040, SZ_LONG, 1'b0, 32'h0, 1'b0, 5, 8'hFB);
        chk("shadow", 32'hA1B2C3D4, resp_rdata);
        // boot codes plus a reserved one; bit 27 does not set the width
        for (int m = 0; m < 4; m++) begin
            cfg(3'(m), 1'b0, 1'b0, 1'b0);
            acc(32'h8000000, SZ_WORD, 1'b0, 32'h0, 1'b0,
                (m == 1 || m == 2) ? 2 : 3,
                (m == 2) ? SEL_IDLE : 8'hFE);
        end
        // upper half of area 5 is 16-bit external
        acc(32'hD000000, SZ_WORD, 1'b0, 32'h0, 1'b1, 2, 8'hDF);
        // area 6 width follows bit 14 in the low half
        acc(32'h6000000, SZ_WORD, 1'b0, 32'h0, 1'b0, 3, 8'hBF);
        acc(32'h6004000, SZ_WORD, 1'b0, 32'h0, 1'b1, 2, 8'hBF);
        acc(32'hE000000, SZ_WORD, 1'b0, 32'h0, 1'b1, 2, 8'hBF);
        // muxed io adds an address phase
        cfg(BOOT_EXT8, 1'b0, 1'b1, 1'b0);
        acc(32'h6000010, SZ_BYTE, 1'b1, 32'h77, 1'b0, 3, 8'hBF);
        // dram space drops the select; multiplexing adds a phase
        cfg(BOOT_EXT8, 1'b1, 1'b0, 1'b0);
        acc(32'h1000010, SZ_BYTE, 1'b0, 32'h0, 1'b0, 2, SEL_IDLE);
        cfg(BOOT_EXT8, 1'b1, 1'b0, 1'b1);
        acc(32'h1C00010, SZ_BYTE, 1'b0, 32'h0, 1'b0, 3, SEL_IDLE);
        // on-chip ram: single beat, no select
        acc(32'hF000040, SZ_LONG, 1'b0, 32'h0, 1'b0, 2, SEL_IDLE);
        chk("ram", 32'hC3000040, resp_rdata);
        @(posedge clock);
        chk("end_sel", {24'h0, SEL_IDLE}, {24'h0, area_select_n});
        give_verdict();
    end
endmodule // adcs_decoder_tb_top
